// *** hdl/tsc_pkg.sv ***
// Shared constants, codes and carrier types for the two-wire slave transmitter
package tsc_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;
  localparam logic [3:0] OWN_OFS  = 4'hc;

  // Control register bit positions
  localparam int CB_DONE  = 7;
  localparam int CB_ACKEN = 6;
  localparam int CB_STA   = 5;
  localparam int CB_STO   = 4;
  localparam int CB_EN    = 2;

  // Own address register: address in [7:1], general call enable in bit 0
  localparam int OB_GCE = 0;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

  // Status codes, prescaler bits zero
  localparam logic [7:0] SC_SLA_R_ACK  = 8'ha8;
  localparam logic [7:0] SC_LOST_SLA_R = 8'hb0;
  localparam logic [7:0] SC_DATA_ACK   = 8'hb8;
  localparam logic [7:0] SC_DATA_NACK  = 8'hc0;
  localparam logic [7:0] SC_LAST_ACK   = 8'hc8;
  localparam logic [7:0] SC_NO_INFO    = 8'hf8;
  localparam logic [7:0] SC_BUS_ERR    = 8'h00;
  localparam logic [7:0] SC_MST_START  = 8'h08;
  localparam logic [7:0] SC_MST_ACK    = 8'h18;
  localparam logic [7:0] SC_MST_NACK   = 8'h20;

  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Master half bit time, rounded up to whole clock cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int MST_HALF_NS   = 5000;
  localparam int MST_HALF_CYC  = (MST_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] DIV_RELOAD = 9'(MST_HALF_CYC - 1);

  // Bus engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_TX, ST_RACK, ST_HOLD,
    ST_BERR, ST_MSTA, ST_MBITS, ST_MHOLD, ST_MSTO
  } tsc_state_e;

  // Synchronised line levels and detected bus events
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } tsc_line_s;

endpackage

// *** hdl/tsc_line_mon.sv ***
// Two-flop synchronisers and edge, START and STOP detection for the bus pins
`timescale 1ns/1ps
module tsc_line_mon
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // Raw bus pins
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  // Registered events
  output tsc_line_s      ln
);

  typedef struct packed {
    logic [1:0] m1;
    logic [1:0] m2;
    logic [1:0] p;
    tsc_line_s  ev;
  } tsc_mon_s;

  tsc_mon_s q;
  tsc_mon_s n;

  // First stage feeds only the second; events look at stages two and three
  always_comb begin
    n = q;
    n.m1 = {scl_i, sda_i};
    n.m2 = q.m1;
    n.p  = q.m2;
    n.ev.scl      = q.m2[1];
    n.ev.sda      = q.m2[0];
    n.ev.scl_rise = q.m2[1] & ~q.p[1];
    n.ev.scl_fall = ~q.m2[1] & q.p[1];
    n.ev.start    = q.m2[1] & q.p[1] & ~q.m2[0] & q.p[0];
    n.ev.stop     = q.m2[1] & q.p[1] & q.m2[0] & ~q.p[0];
  end

  // Idle bus is high, so reset to high to avoid false events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.m1 <= 2'h3;
      q.m2 <= 2'h3;
      q.p  <= 2'h3;
      q.ev.scl <= 1'b1;
      q.ev.sda <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign ln = q.ev;

endmodule

// *** hdl/tsc_slave_tx.sv ***
// Two-wire slave transmitter with status codes, master start and register slave
//
// What this block does
// - Data register not refreshed from bus traffic
// - Own read address acked: flag, code a8
// - Lost arbitration then addressed: code b0
// - Data acked by master: code b8
// - Data not acked by master: code c0
// - Final byte still acked: code c8
// - Ack enable zero sends final byte
// - Ack enable one expects master ack
// - After c0/c8, ack enable zero ignores addresses
// - After c0/c8, ack enable one recognises addresses
// - Start bit set: START when bus free
// - Flag clear: status reads f8
// - Misplaced START or STOP: code 00
// - Bus error sets job done flag
// - Recovery: unaddressed, stop bit self clears
// - Recovery releases lines, sends no STOP
// - Repeated START keeps bus ownership
// - Status in bits 7:3, prescaler 1:0
// - Flag set stretches clock except on bus error; one clears
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module tsc_slave_tx
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM register slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Open-drain bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  typedef struct packed {
    tsc_state_e  st;
    logic        jd;
    logic        ack_en;
    logic        start_request_bit;
    logic        stop_request_bit;
    logic        en;
    logic [1:0]  psc;
    logic [7:0]  code;
    logic [7:0]  dreg;
    logic [7:0]  own;
    logic [7:0]  sh;
    logic [3:0]  bits;
    logic [1:0]  ph;
    logic        lost;
    logic        last;
    logic        mack;
    logic        busy;
    logic        scl_lo;
    logic        sda_lo;
    logic        acked;
    logic [8:0]  cnt;
    logic [31:0] rdata;
  } tsc_core_s;

  tsc_core_s  q;
  tsc_core_s  n;
  tsc_line_s  ln;
  logic       req;
  logic       do_wr;
  logic       ctl_wr;
  logic       clr;
  logic       tick;
  logic       frame_err;
  logic [7:0] wd;
  logic [7:0] stat_rd;

  // Own address, or general call when enabled, while acks are on
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own,
                                    input logic acken);
    addr_hit = acken & ((rx[7:1] == own[7:1]) |
                        ((rx[7:1] == GEN_CALL_ADDR) & own[OB_GCE]));
  endfunction

  tsc_line_mon u_mon (
    .clk   (clk),
    .rst   (rst),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ln    (ln)
  );

  // Bus strobes; one wait state on every access
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~q.acked;
  assign do_wr           = avs_write & q.acked & avs_byteenable[0];
  assign wd              = avs_writedata[7:0];
  assign ctl_wr          = do_wr && (avs_address == CTRL_OFS);
  assign clr             = ctl_wr && wd[CB_DONE];
  assign tick            = (q.cnt == 9'h000);

  assign stat_rd = {(q.jd ? q.code[7:3] : SC_NO_INFO[7:3]), 1'b0, q.psc};

  // Misplaced START or STOP inside a frame
  assign frame_err = (ln.start || ln.stop) &&
                     ((q.st == ST_AACK) || (q.st == ST_TX) || (q.st == ST_RACK) ||
                      ((q.st == ST_ADDR) && (q.bits != 4'h0)));

  // Next state of registers and bus engine
  always_comb begin
    n = q;
    n.acked = req & ~q.acked;
    if (req && !q.acked) begin
      n.rdata = 32'h0000_0000;
      case (avs_address)
        CTRL_OFS: n.rdata[7:0] = {q.jd, q.ack_en, q.start_request_bit, q.stop_request_bit, 1'b0, q.en, 2'b00};
        STAT_OFS: n.rdata[7:0] = stat_rd;
        DATA_OFS: n.rdata[7:0] = q.dreg;
        OWN_OFS:  n.rdata[7:0] = q.own;
        default:  n.rdata = 32'h0000_0000;
      endcase
    end
    if (do_wr) begin
      case (avs_address)
        CTRL_OFS: begin
          n.ack_en = wd[CB_ACKEN];
          n.start_request_bit    = wd[CB_STA];
          n.stop_request_bit    = wd[CB_STO];
          n.en     = wd[CB_EN];
        end
        STAT_OFS: n.psc = wd[1:0];
        DATA_OFS: n.dreg = wd;
        OWN_OFS:  n.own = wd;
        default: ;
      endcase
    end
    // Clear first so a hardware set later in this cycle wins
    if (clr) begin
      n.jd = 1'b0;
    end
    n.cnt = tick ? DIV_RELOAD : q.cnt - 9'h001;
    if (ln.start) begin
      n.busy = 1'b1;
    end
    if (ln.stop) begin
      n.busy = 1'b0;
    end

    case (q.st)
      ST_IDLE: begin
        n.scl_lo = 1'b0;
        n.sda_lo = 1'b0;
        if (ln.start) begin
          n.st   = ST_ADDR;
          n.bits = 4'h0;
          n.lost = 1'b0;
        end else if (q.start_request_bit && !q.busy && !q.jd) begin
          n.st = ST_MSTA;
          n.ph = 2'h0;
        end
      end
      ST_ADDR: begin
        if (ln.scl_rise) begin
          n.sh   = {q.sh[6:0], ln.sda};
          n.bits = q.bits + 4'h1;
        end else if (ln.scl_fall && q.bits == BYTE_BITS) begin
          if (addr_hit(q.sh, q.own, q.ack_en) && q.sh[0] &&
              (q.sh[7:1] != GEN_CALL_ADDR)) begin
            n.sda_lo = 1'b1;
            n.st     = ST_AACK;
          end else begin
            n.st = ST_IDLE;
          end
        end else if (ln.stop) begin
          n.st = ST_IDLE;
        end
      end
      ST_AACK: begin
        if (ln.scl_fall) begin
          n.sda_lo = 1'b0;
          n.scl_lo = 1'b1;
          n.jd     = 1'b1;
          n.code   = q.lost ? SC_LOST_SLA_R : SC_SLA_R_ACK;
          n.st     = ST_HOLD;
        end
      end
      ST_HOLD: begin
        n.scl_lo = 1'b1;
        if (clr) begin
          n.scl_lo = 1'b0;
          if (q.code == SC_DATA_NACK || q.code == SC_LAST_ACK) begin
            n.sda_lo = 1'b0;
            n.st     = ST_IDLE;
          end else begin
            // final byte when ack enable low
            n.sh     = q.dreg;
            n.bits   = 4'h0;
            n.last   = ~n.ack_en;
            n.sda_lo = ~q.dreg[7];
            n.st     = ST_TX;
          end
        end
      end
      ST_TX: begin
        if (ln.scl_fall) begin
          n.bits   = q.bits + 4'h1;
          n.sh     = {q.sh[6:0], 1'b1};
          n.sda_lo = ~q.sh[6];
          if (q.bits == BYTE_BITS - 4'h1) begin
            n.sda_lo = 1'b0;
            n.st     = ST_RACK;
          end
        end
      end
      ST_RACK: begin
        if (ln.scl_rise) begin
          n.mack = ~ln.sda;
        end else if (ln.scl_fall) begin
          // code from ack and final mark
          n.jd     = 1'b1;
          n.scl_lo = 1'b1;
          n.st     = ST_HOLD;
          if (!q.mack) begin
            n.code = SC_DATA_NACK;
          end else begin
            n.code = q.last ? SC_LAST_ACK : SC_DATA_ACK;
          end
        end
      end
      ST_BERR: begin
        // both lines released, no STOP driven
        n.scl_lo = 1'b0;
        n.sda_lo = 1'b0;
        // back to unaddressed, stop bit self clears
        if (clr && n.stop_request_bit) begin
          n.stop_request_bit = 1'b0;
          n.st  = ST_IDLE;
        end
      end
      ST_MSTA: begin
        case (q.ph)
          2'h0: begin
            n.sda_lo = 1'b0;
            if (tick) begin
              n.scl_lo = 1'b0;
              n.ph     = 2'h1;
            end
          end
          2'h1: begin
            if (tick && ln.scl) begin
              n.sda_lo = 1'b1;
              n.ph     = 2'h2;
            end
          end
          default: begin
            if (tick) begin
              n.scl_lo = 1'b1;
              n.jd     = 1'b1;
              n.code   = SC_MST_START;
              n.st     = ST_MHOLD;
            end
          end
        endcase
      end
      ST_MHOLD: begin
        // clock stays low, nobody else gets the bus
        n.scl_lo = 1'b1;
        if (clr) begin
          n.ph = 2'h0;
          if (n.stop_request_bit) begin
            n.st = ST_MSTO;
          // repeated START from an owned bus
          end else if (n.start_request_bit) begin
            n.st = ST_MSTA;
          end else begin
            n.sh     = q.dreg;
            n.bits   = 4'h0;
            n.lost   = 1'b0;
            n.sda_lo = ~q.dreg[7];
            n.st     = ST_MBITS;
          end
        end
      end
      ST_MBITS: begin
        if (q.ph == 2'h0) begin
          if (tick) begin
            n.scl_lo = 1'b0;
            n.ph     = 2'h1;
          end
        end else if (tick && ln.scl) begin
          if (q.bits == BYTE_BITS) begin
            n.scl_lo = 1'b1;
            n.jd     = 1'b1;
            n.code   = ln.sda ? SC_MST_NACK : SC_MST_ACK;
            n.st     = ST_MHOLD;
          // lost a one: drop to slave, keep the address bits
          end else if (!q.sda_lo && !ln.sda) begin
            n.lost   = 1'b1;
            n.scl_lo = 1'b0;
            n.sh     = {q.sh[6:0], 1'b0};
            n.bits   = q.bits + 4'h1;
            n.st     = ST_ADDR;
          end else begin
            n.sh     = {q.sh[6:0], ln.sda};
            n.bits   = q.bits + 4'h1;
            n.scl_lo = 1'b1;
            n.sda_lo = (q.bits == BYTE_BITS - 4'h1) ? 1'b0 : ~q.sh[6];
            n.ph     = 2'h0;
          end
        end
      end
      ST_MSTO: begin
        if (q.ph == 2'h0) begin
          n.sda_lo = 1'b1;
          if (tick) begin
            n.scl_lo = 1'b0;
            n.ph     = 2'h1;
          end
        end else if (tick && ln.scl) begin
          n.sda_lo = 1'b0;
          n.stop_request_bit    = 1'b0;
          n.st     = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    if (frame_err) begin
      n.st     = ST_BERR;
      n.jd     = 1'b1;
      n.code   = SC_BUS_ERR;
      n.scl_lo = 1'b0;
      n.sda_lo = 1'b0;
    end
    // Disabled interface lets go of the bus at once
    if (!n.en) begin
      n.st     = ST_IDLE;
      n.scl_lo = 1'b0;
      n.sda_lo = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q      <= '0;
      q.code <= SC_NO_INFO;
      q.cnt  <= DIV_RELOAD;
    end else begin
      q <= n;
    end
  end

  // Readback and pin enables from flops; pins only ever pulled low
  assign avs_readdata = q.rdata;
  assign scl_o        = 1'b0;
  assign sda_o        = 1'b0;
  assign scl_oe       = q.scl_lo;
  assign sda_oe       = q.sda_lo;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_quiet;
    !ln.start && !ln.stop && !ctl_wr;
  endsequence
  sequence s_aack_done;
    q.en && q.st == ST_AACK && ln.scl_fall ##0 s_quiet;
  endsequence
  sequence s_rack_done;
    q.en && q.st == ST_RACK && ln.scl_fall ##0 s_quiet;
  endsequence
  sequence s_hold_clr;
    q.en && q.st == ST_HOLD && clr && wd[CB_EN];
  endsequence

  AST_NO_INFO: assert property (!q.jd |-> stat_rd[7:2] == 6'h3e)
    else $error("status not f8 while flag clear");
  AST_OWN_READ: assert property (s_aack_done ##0 !q.lost |=>
    q.jd && q.code == SC_SLA_R_ACK && scl_oe ##1 q.st == ST_HOLD)
    else $error("own read address not reported as a8");
  AST_LOST_READ: assert property (s_aack_done ##0 q.lost |=>
    q.jd && q.code == SC_LOST_SLA_R)
    else $error("lost arbitration read not reported as b0");
  AST_DATA_ACK: assert property (s_rack_done ##0 (q.mack && !q.last) |=>
    q.jd && q.code == SC_DATA_ACK && scl_oe)
    else $error("acked data not reported as b8");
  AST_DATA_NACK: assert property (s_rack_done ##0 !q.mack |=> q.code == SC_DATA_NACK)
    else $error("nacked data not reported as c0");
  AST_LAST_ACK: assert property (s_rack_done ##0 (q.mack && q.last) |=>
    q.code == SC_LAST_ACK)
    else $error("acked final byte not reported as c8");
  AST_TX_LOAD: assert property (s_hold_clr ##0 q.code[7:6] == 2'h2 |=>
    q.st == ST_TX && q.sda_lo == !$past(q.dreg[7]) && q.last == !$past(wd[CB_ACKEN]))
    else $error("byte not loaded with final mark on flag clear");
  AST_UNADDR: assert property (s_hold_clr ##0 q.code[7:6] == 2'h3 |=>
    q.st == ST_IDLE && !scl_oe && !sda_oe)
    else $error("not unaddressed after c0 or c8");
  AST_BUS_ERR: assert property ((q.en && ln.start && !ctl_wr &&
    ((q.st == ST_TX) || (q.st == ST_ADDR && q.bits != 4'h0))) |=>
    q.st == ST_BERR && q.jd && q.code == SC_BUS_ERR)
    else $error("start inside data byte not flagged as bus error");
  AST_RECOVER: assert property ((q.st == ST_BERR && clr && wd[CB_STO] && wd[CB_EN]) |=>
    q.st == ST_IDLE && !q.stop_request_bit && q.ack_en == $past(wd[CB_ACKEN]) && q.en)
    else $error("bus error recovery wrong");
  AST_RELEASE: assert property (q.st == ST_BERR |-> !scl_oe && !sda_oe)
    else $error("lines driven during bus error");

endmodule

// *** dv/tsc_bus_master.sv ***
// Behavioural two-wire bus master receiver driving open-drain pulls
`timescale 1ns/1ps
module tsc_bus_master #(
  parameter int QTR = 4
) (
  // Clock
  input  wire logic clk,
  // Wire levels seen on the bus
  input  wire logic scl,
  input  wire logic sda,
  // Pull-down enables, high pulls the line low
  output logic      scl_oe,
  output logic      sda_oe
);
  // Both lines released at time zero, pull-ups hold them high
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rise();
    int k;
    scl_oe <= 1'b0;
    k = 0;
    tick(1);
    // Bounded so a stuck slave shows up as a watchdog hit
    while (scl !== 1'b1 && k < 20000) begin
      tick(1);
      k++;
    end
  endtask

  // Start or repeated start, ends with the clock low
  // repeated start keeps the bus
  task automatic start();
    sda_oe <= 1'b0;
    tick(QTR);
    rise();
    tick(QTR);
    sda_oe <= 1'b1;
    tick(QTR);
    scl_oe <= 1'b1;
    tick(QTR);
  endtask

  task automatic stop();
    sda_oe <= 1'b1;
    tick(QTR);
    rise();
    tick(QTR);
    sda_oe <= 1'b0;
    tick(QTR);
  endtask

  // Data set mid low phase, one 17 cycle bit
  task automatic put_bit(input logic b);
    sda_oe <= ~b;
    tick(QTR);
    rise();
    tick(2 * QTR);
    scl_oe <= 1'b1;
    tick(QTR);
  endtask

  task automatic get_bit(output logic b);
    sda_oe <= 1'b0;
    tick(QTR);
    rise();
    tick(QTR);
    b = sda;
    tick(QTR);
    scl_oe <= 1'b1;
    tick(QTR);
  endtask

  task automatic put_byte(input logic [7:0] v, output logic nak);
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(nak);
  endtask

  // contender holds data low in the first bit, then clocks the rest
  task automatic steal(input logic [6:0] rest, output logic nak);
    int k;
    sda_oe <= 1'b1;
    k = 0;
    while (scl !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    // Longer than one half bit so the other side samples the low first
    tick(600);
    scl_oe <= 1'b1;
    tick(QTR);
    for (int i = 6; i >= 0; i--) put_bit(rest[i]);
    get_bit(nak);
  endtask

  task automatic get_byte(output logic [7:0] v, input logic nak);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(nak);
  endtask
endmodule

// *** dv/tsc_slave_tx_test.sv ***
// Self-checking bench for the slave transmitter status behaviour
`timescale 1ns/1ps
module tsc_slave_tx_test;
  import tsc_pkg::*;

  logic        clk;
  logic        rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        scl_oe;
  logic        sda_oe;
  logic        m_scl_oe;
  logic        m_sda_oe;
  logic        scl_w;
  logic        sda_w;
  int          failures;
  int          tests_run;
  int          seed;

  // Wired-AND with pull-ups
  assign scl_w = ~(scl_oe | m_scl_oe);
  assign sda_w = ~(sda_oe | m_sda_oe);

  tsc_slave_tx dut_u (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe)
  );

  tsc_bus_master #(.QTR(4)) bm (
    .clk(clk), .scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] be = 4'hf);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= v;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // Poll control until the job done flag shows
  task automatic wait_done();
    logic [31:0] d;
    d = 32'h0;
    for (int k = 0; k < 1500 && d[CB_DONE] !== 1'b1; k++) bus_rd(CTRL_OFS, d);
    check(32'(d[CB_DONE]), 32'h1, "job done flag");
  endtask

  task automatic exp_status(input logic [7:0] code);
    logic [31:0] d;
    bus_rd(STAT_OFS, d);
    check(d, {24'h0, code}, "status code");
  endtask

  // Addresses the slave for reading, expects the ack answer given
  task automatic address(input logic [6:0] a, input logic exp_nak);
    logic nak;
    bm.start();
    bm.put_byte({a, 1'b1}, nak);
    check(32'(nak), 32'(exp_nak), "address answer");
  endtask

  // Loads one byte, lets the master fetch it and checks what it saw
  task automatic send(input logic last, input logic nak, input logic [7:0] code);
    logic [7:0]  dat;
    logic [7:0]  got;
    logic [31:0] d;
    dat = 8'($random(seed));
    bus_wr(DATA_OFS, {24'h0, dat});
    bus_wr(DATA_OFS, {24'h0, ~dat}, 4'h0);
    bus_rd(DATA_OFS, d);
    check(d, {24'h0, dat}, "data register");
    bus_wr(CTRL_OFS, last ? 32'h84 : 32'hc4);
    bm.get_byte(got, nak);
    check(32'(got), 32'(dat), "byte on wire");
    wait_done();
    exp_status(code);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    logic [6:0]  own;
    int          n;
    logic        nak_seen;
    seed = 92;
    failures = 0;
    tests_run = 0;
    rst <= 1'b1;
    avs_address <= 4'h0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    avs_byteenable <= 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    bus_rd(STAT_OFS, d);
    check(d, 32'hf8, "idle status");
    bus_rd(CTRL_OFS, d);
    check(d, 32'h0, "control reset");
    bus_wr(STAT_OFS, 32'h03);
    bus_rd(STAT_OFS, d);
    check(d, 32'hfb, "prescaler beside code");
    bus_wr(STAT_OFS, 32'h0);
    bus_rd(4'h6, d);
    check(d, 32'h0, "unmapped read");
    // Top address bit zero so a contender can win the first bit
    own = (7'($random(seed)) & 7'h3f) | 7'h08;
    bus_wr(OWN_OFS, {24'h0, own, 1'b0});
    bus_wr(CTRL_OFS, 32'h44);
    // Acked bytes, then a final byte the master refuses
    address(own, 1'b0);
    wait_done();
    exp_status(SC_SLA_R_ACK);
    n = 2 + ($unsigned($random(seed)) % 3);
    for (int i = 0; i < n; i++) send(1'b0, 1'b0, SC_DATA_ACK);
    send(1'b1, 1'b1, SC_DATA_NACK);
    bus_wr(CTRL_OFS, 32'h84);
    exp_status(SC_NO_INFO);
    address(own, 1'b1);
    bm.stop();
    // Final byte acked anyway, then address recognition resumes
    bus_wr(CTRL_OFS, 32'h44);
    address(own, 1'b0);
    wait_done();
    send(1'b1, 1'b0, SC_LAST_ACK);
    bus_wr(CTRL_OFS, 32'hc4);
    address(GEN_CALL_ADDR, 1'b1);
    address(own, 1'b0);
    wait_done();
    send(1'b1, 1'b1, SC_DATA_NACK);
    // Leaving with a start request claims the bus once it is free
    bus_wr(CTRL_OFS, 32'ha4);
    bm.stop();
    wait_done();
    exp_status(SC_MST_START);
    bus_wr(CTRL_OFS, 32'h94);
    d = 32'h10;
    for (int k = 0; k < 1500 && d[CB_STO] !== 1'b0; k++) bus_rd(CTRL_OFS, d);
    check(d, 32'h04, "stop request self clears");
    // Claim, restart, then lose the first address bit to a contender
    bus_wr(CTRL_OFS, 32'he4);
    wait_done();
    bus_wr(CTRL_OFS, 32'he4);
    wait_done();
    exp_status(SC_MST_START);
    bus_wr(DATA_OFS, {24'h0, 1'b1, own[5:0], 1'b1});
    bus_wr(CTRL_OFS, 32'hc4);
    bm.steal({own[5:0], 1'b1}, nak_seen);
    check(32'(nak_seen), 32'h0, "address after lost arbitration");
    wait_done();
    exp_status(SC_LOST_SLA_R);
    send(1'b1, 1'b1, SC_DATA_NACK);
    bus_wr(CTRL_OFS, 32'h84);
    bm.stop();
    // Misplaced start inside an address byte
    bus_wr(CTRL_OFS, 32'h44);
    bm.start();
    for (int i = 0; i < 3; i++) bm.put_bit(own[6 - i]);
    bm.start();
    wait_done();
    exp_status(SC_BUS_ERR);
    check(32'({scl_oe, sda_oe}), 32'h0, "lines released");
    bus_wr(CTRL_OFS, 32'hd4);
    bus_rd(CTRL_OFS, d);
    check(d, 32'h44, "recovery control");
    exp_status(SC_NO_INFO);
    check(32'({scl_oe, sda_oe}), 32'h0, "no stop driven");
    bm.stop();
    address(own, 1'b0);
    wait_done();
    send(1'b1, 1'b1, SC_DATA_NACK);
    bus_wr(CTRL_OFS, 32'h84);
    bm.stop();
    tally_and_finish();
  end
endmodule
